// >>> tms_top.sv
`timescale 1ns/1ns
`default_nettype none
module tms_top #(
  parameter int unsigned BEAMS = 32,
  parameter int unsigned MIN_CYC = tms_pkg::PULSE_MIN_CYC,
  parameter int unsigned MAX_CYC = tms_pkg::PULSE_MAX_CYC,
  parameter int unsigned NIO = 3,
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic configurable_line_one,
  input wire logic npn_config,
  input wire logic cmd_teach,
  input wire logic cmd_mode_toggle,
  input wire logic cmd_factory_reset,
  input wire logic cfg_powerup_teach,
  input wire logic cfg_nonvolatile_wr,
  input wire logic cfg_nonvolatile,
  input wire logic reserve_wr,
  input wire logic [2:0] reserve_sel,
  input wire logic [2:0] blank_areas,
  input wire logic [BEAMS-1:0] beam_blocked,
  input wire logic [tms_pkg::LEVEL_W-1:0] rx_first_level,
  input wire logic [tms_pkg::LEVEL_W-1:0] rx_last_level,
  input wire logic [NIO-1:0] io_states,
  output logic busy,
  output logic teach_done,
  output logic teach_error,
  output logic alignment_mode,
  output logic [1:0] view,
  output logic [tms_pkg::LEVEL_W-1:0] first_beam_level,
  output logic [tms_pkg::LEVEL_W-1:0] last_beam_level,
  output logic [7:0] interrupted_beam_total,
  output logic [NIO-1:0] io_view,
  output logic [2:0] reserve_level,
  output logic [2:0] regulate_level,
  output logic regulate_all,
  output logic store_nonvolatile,
  output logic [BEAMS-1:0] beam_enable
);
  import tms_pkg::*;

  typedef enum logic [1:0] {
    TMS_ST_POWERUP = 2'h0,
    TMS_ST_IDLE = 2'h1,
    TMS_ST_TEACH = 2'h2,
    TMS_ST_FINISH = 2'h3
  } tms_state_e;

  typedef struct packed {
    tms_state_e state;
    tms_src_e src;
    logic from_align;
    logic align;
    logic [1:0] view;
    logic busy;
    logic done;
    logic error;
    logic [LEVEL_W-1:0] fb;
    logic [LEVEL_W-1:0] lb;
    logic [7:0] total;
    logic [NIO-1:0] io;
    logic [2:0] reserve;
    logic regulate;
    logic nonvol;
    logic fail;
    logic [BEAMS-1:0] enable;
  } tms_top_s;

  tms_top_s st_q, st_d;
  logic line_pulse;
  logic [BEAMS-1:0] widened;
  logic [7:0] blocked_cnt;
  logic [2:0] region_cnt;

  tms_pulse #(
    .MIN_CYC(MIN_CYC),
    .MAX_CYC(MAX_CYC),
    .CNT_W(CNT_W)
  ) u_pulse (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .line_raw(configurable_line_one),
    .active_low(npn_config),
    .teach_pulse(line_pulse)
  );

  function automatic logic [7:0] count_ones(input logic [BEAMS-1:0] v);
    logic [7:0] n;
    n = '0;
    for (int i = 0; i < BEAMS; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  function automatic logic [BEAMS-1:0] widen(input logic [BEAMS-1:0] v);
    logic [BEAMS-1:0] w;
    w = v;
    for (int k = 0; k < BLANK_MARGIN; k++) begin
      w = w | (w << 1) | (w >> 1);
    end
    return w;
  endfunction

  function automatic logic [2:0] count_regions(input logic [BEAMS-1:0] v);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < BEAMS; i++) begin
      if (v[i] && (i == 0 || !v[i-1]) && n != 3'h7) begin
        n = n + 3'h1;
      end
    end
    return n;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    widened = widen(beam_blocked); // R6
    blocked_cnt = count_ones(beam_blocked);
    region_cnt = count_regions(widened);
    st_d.total = blocked_cnt; // R18
    st_d.io = io_states; // R18
    if (reserve_wr && reserve_sel <= 3'(TMS_FR_TXRX)) begin
      st_d.reserve = reserve_sel; // R19
    end
    if (cfg_nonvolatile_wr) begin
      st_d.nonvol = cfg_nonvolatile; // R8
    end
    if (cmd_factory_reset) begin
      st_d.reserve = 3'(TMS_FR_HIGH); // R20
      st_d.nonvol = 1'b1; // R8
    end
    if (st_q.align) begin
      st_d.fb = rx_first_level;
      st_d.lb = rx_last_level;
    end
    case (st_q.state)
      TMS_ST_POWERUP: begin
        st_d.state = TMS_ST_IDLE;
        if (cfg_powerup_teach) begin
          st_d.state = TMS_ST_TEACH; // R16
          st_d.src = TMS_SRC_POWERUP;
          st_d.from_align = st_q.align;
          st_d.busy = 1'b1;
          st_d.view = 2'(TMS_VIEW_BUSY);
        end
      end
      TMS_ST_IDLE: begin
        if (cmd_mode_toggle) begin
          st_d.align = !st_q.align; // R17
          st_d.view = st_q.align ? 2'(TMS_VIEW_PROCESS) : 2'(TMS_VIEW_BARS);
        end
        // panel or line request accepted in either mode
        if (cmd_teach || line_pulse) begin // R9
          st_d.state = TMS_ST_TEACH;
          st_d.src = cmd_teach ? TMS_SRC_PANEL : TMS_SRC_LINE;
          st_d.from_align = st_q.align;
          st_d.busy = 1'b1; // R10
          st_d.view = 2'(TMS_VIEW_BUSY); // R10
        end
      end
      TMS_ST_TEACH: begin
        st_d.state = TMS_ST_FINISH;
        st_d.fail = 1'b0;
        if (rx_first_level < LEVEL_MID || rx_last_level < LEVEL_MID) begin
          st_d.fail = 1'b1; // R3
        end else if (blank_areas == 3'h0) begin
          st_d.enable = {BEAMS{1'b1}};
          if (blocked_cnt != 8'h00) begin
            st_d.fail = 1'b1; // R5
          end
        end else if (region_cnt > 3'(MAX_BLANK_AREAS) || region_cnt > blank_areas) begin
          st_d.fail = 1'b1; // R7
        end else begin
          st_d.enable = ~widened; // R6
        end
        st_d.regulate = !st_d.fail; // R4
      end
      TMS_ST_FINISH: begin
        st_d.state = TMS_ST_IDLE;
        st_d.regulate = 1'b0;
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
        st_d.error = st_q.fail;
        if (st_q.fail) begin
          st_d.fb = LEVEL_BLANK; // R15
          st_d.lb = LEVEL_BLANK; // R15
          st_d.view = 2'(TMS_VIEW_BARS);
          st_d.align = 1'b1;
        end else begin
          st_d.fb = LEVEL_FULL; // R14
          st_d.lb = LEVEL_FULL; // R14
          if (st_q.src == TMS_SRC_LINE) begin
            st_d.view = 2'(TMS_VIEW_BARS); // R13
            st_d.align = 1'b1; // R13
          end else if (st_q.from_align) begin
            st_d.view = 2'(TMS_VIEW_BARS); // R12
          end else begin
            st_d.view = 2'(TMS_VIEW_PROCESS); // R11
          end
        end
      end
      default: begin
        st_d.state = TMS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.state <= TMS_ST_POWERUP;
      st_q.align <= 1'b0; // R21
      st_q.view <= 2'(TMS_VIEW_PROCESS); // R21
      st_q.reserve <= 3'(TMS_FR_HIGH); // R20
      st_q.nonvol <= 1'b1; // R8
      st_q.enable <= {BEAMS{1'b1}};
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign teach_done = st_q.done;
  assign teach_error = st_q.error;
  assign alignment_mode = st_q.align;
  assign view = st_q.view;
  assign first_beam_level = st_q.fb;
  assign last_beam_level = st_q.lb;
  assign interrupted_beam_total = st_q.total;
  assign io_view = st_q.io;
  assign reserve_level = st_q.reserve;
  assign regulate_level = st_q.reserve; // R4
  assign regulate_all = st_q.regulate;
  assign store_nonvolatile = st_q.nonvol;
  assign beam_enable = st_q.enable;
endmodule
`default_nettype wire

// >>> tms_pkg.sv
// Notes on behaviour
// R1: teach pulse valid between 20 and 80 ms
// R2: teach line polarity follows switching type
// R3: refuse teach below mid-scale level mark
// R4: teach regulates all beams to reserve
// R5: interrupted beam without blanking gives error
// R6: blanking deactivates interrupted beams plus margin
// R7: at most four blanking regions
// R8: storage option, factory default non-volatile
// R9: teach accepted in process or alignment
// R10: busy indication while teach runs
// R11: panel teach from process returns there
// R12: teach from alignment returns to bars
// R13: line teach returns to bar indicator
// R14: success shows full scale on both bars
// R15: failure blanks both bar indicators
// R16: power-up teach after power applied
// R17: menu command toggles process and alignment
// R18: process view shows interrupted count and IOs
// R19: six function-reserve settings
// R20: reserve defaults to high after factory reset
// R21: factory start in process mode
// R22: out-of-window teach pulses are ignored
package tms_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PULSE_MIN_MS = 20;
  localparam int unsigned PULSE_MAX_MS = 80;
  localparam int unsigned PULSE_MIN_CYC = PULSE_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned LEVEL_W = 8;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'hff;
  localparam logic [LEVEL_W-1:0] LEVEL_BLANK = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_MID = 8'h80;
  localparam int unsigned MAX_BLANK_AREAS = 4;
  localparam int unsigned BLANK_MARGIN = 1;

  typedef enum logic [2:0] {
    TMS_FR_HIGH = 3'h0,
    TMS_FR_MEDIUM = 3'h1,
    TMS_FR_LOW = 3'h2,
    TMS_FR_TRANSPARENT = 3'h3,
    TMS_FR_TARGET = 3'h4,
    TMS_FR_TXRX = 3'h5
  } tms_reserve_e;

  typedef enum logic [1:0] {
    TMS_VIEW_PROCESS = 2'h0,
    TMS_VIEW_BARS = 2'h1,
    TMS_VIEW_BUSY = 2'h2
  } tms_view_e;

  typedef enum logic [1:0] {
    TMS_SRC_PANEL = 2'h0,
    TMS_SRC_LINE = 2'h1,
    TMS_SRC_POWERUP = 2'h2
  } tms_src_e;
endpackage

// >>> tms_pulse.sv
`timescale 1ns/1ns
`default_nettype none
module tms_pulse #(
  parameter int unsigned MIN_CYC = tms_pkg::PULSE_MIN_CYC,
  parameter int unsigned MAX_CYC = tms_pkg::PULSE_MAX_CYC,
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic line_raw,
  input wire logic active_low,
  output logic teach_pulse
);
  import tms_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [CNT_W-1:0] width;
    logic pulse;
  } tms_pulse_s;

  tms_pulse_s st_q, st_d;
  logic active;
  logic agreed;

  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    st_d.sync = {st_q.sync[1:0], line_raw};
    agreed = (st_q.sync[1] == st_q.sync[2]);
    // sense of the line flips with the switching type
    active = st_q.sync[2] ^ active_low; // R2
    if (agreed) begin
      st_d.level = active;
      if (active) begin
        if (st_q.width != {CNT_W{1'b1}}) begin
          st_d.width = st_q.width + 1'b1;
        end
      end else begin
        st_d.width = '0;
        // the last active sample is not agreed (sync[1] has already changed), so the count trails the true width by one
        if (st_q.level && st_q.width >= CNT_W'(MIN_CYC) && st_q.width < CNT_W'(MAX_CYC - 1)) begin
          st_d.pulse = 1'b1; // R1 R22
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign teach_pulse = st_q.pulse;
endmodule
`default_nettype wire

// >>> tms_props.sv
`timescale 1ns/1ns
`default_nettype none
module tms_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reserve_wr,
  input wire logic [2:0] reserve_sel,
  input wire logic [tms_pkg::LEVEL_W-1:0] rx_first_level,
  input wire logic busy,
  input wire logic teach_done,
  input wire logic teach_error,
  input wire logic alignment_mode,
  input wire logic [1:0] view,
  input wire logic [tms_pkg::LEVEL_W-1:0] first_beam_level,
  input wire logic [tms_pkg::LEVEL_W-1:0] last_beam_level,
  input wire logic [2:0] reserve_level,
  input wire logic [2:0] regulate_level,
  input wire logic regulate_all
);
  import tms_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_busy_view: assert property (busy |-> view == 2'h2)
    else $error("busy view missing");
  chk_teach_len: assert property ($rose(busy) |-> busy ##1 !teach_done ##1 teach_done)
    else $error("teach length wrong");
  chk_pass_full: assert property (teach_done && !teach_error |->
    first_beam_level == LEVEL_FULL && last_beam_level == LEVEL_FULL)
    else $error("pass bars not full");
  chk_fail_blank: assert property (teach_done && teach_error |->
    first_beam_level == LEVEL_BLANK && last_beam_level == LEVEL_BLANK)
    else $error("fail bars not blank");
  chk_fail_view: assert property (teach_done && teach_error |-> alignment_mode && view == 2'h1)
    else $error("fail view wrong");
  chk_regulate_pass: assert property (regulate_all |=> teach_done && !teach_error)
    else $error("regulate without pass");
  chk_regulate_level: assert property (regulate_level == reserve_level)
    else $error("regulate level differs");
  chk_low_refused: assert property ($rose(busy) && rx_first_level < LEVEL_MID |-> ##2 teach_error)
    else $error("low level accepted");
  chk_reserve_code: assert property (reserve_wr && reserve_sel < 3'h6 |=> reserve_level == $past(reserve_sel))
    else $error("reserve not taken");
  cover property (teach_done && !teach_error);
  cover property (teach_done && teach_error);
  cover property ($rose(alignment_mode));
endmodule
bind tms_top tms_props tms_props_inst (.*);
`default_nettype wire

// >>> tms_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module tms_ctrl_model (
  input wire logic clk_sys,
  input wire logic npn_config,
  output logic configurable_line_one
);
  logic act = 1'h0;
  // idle level follows the switching type
  assign configurable_line_one = act ^ npn_config;
  task automatic pulse(input int w);
    @(negedge clk_sys) act = 1'h1;
    repeat (w) @(negedge clk_sys);
    act = 1'h0;
  endtask
endmodule
`default_nettype wire

// >>> tms_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tms_top_tb_top;
  import tms_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic configurable_line_one, npn_config = 1'h0, cmd_teach = 1'h0, cmd_mode_toggle = 1'h0;
  logic cmd_factory_reset = 1'h0, cfg_powerup_teach = 1'h1, cfg_nonvolatile_wr = 1'h0;
  logic cfg_nonvolatile = 1'h1, reserve_wr = 1'h0;
  logic [2:0] reserve_sel = 3'h0, blank_areas = 3'h0, reserve_level, regulate_level;
  logic [15:0] beam_blocked = 16'h0, beam_enable;
  logic [7:0] rx_first_level = 8'hff, rx_last_level = 8'hff, first_beam_level, last_beam_level;
  logic [7:0] interrupted_beam_total;
  logic [2:0] io_states = 3'h0, io_view;
  logic busy, teach_done, teach_error, alignment_mode, regulate_all, store_nonvolatile;
  logic [1:0] view;
  logic [11:0] exp_q[$];
  int err_count = 0, n_checks = 0, n_done = 0, cyc = 0, seed = 26439;
  always #5 clk_sys = ~clk_sys;
  tms_top #(.BEAMS(16), .MIN_CYC(20), .MAX_CYC(80)) tms_top_inst (.*);
  tms_ctrl_model tms_ctrl_model_inst (.*);
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // result check: {error, alignment, view, first bar}
  always @(negedge clk_sys)
    if (teach_done === 1'h1) begin
      n_done++;
      chk("pending", exp_q.size() != 0, 1'h1);
      if (exp_q.size() != 0)
        chk("result", {teach_error, alignment_mode, view, first_beam_level}, exp_q.pop_front());
    end
  task automatic teach(input logic [11:0] e, input int w);
    int n0;
    n0 = n_done;
    exp_q.push_back(e);
    if (w == 0) begin
      @(negedge clk_sys) cmd_teach = 1'h1;
      @(negedge clk_sys) cmd_teach = 1'h0;
    end else
      tms_ctrl_model_inst.pulse(w);
    repeat (100) @(negedge clk_sys) if (n_done > n0) break;
    repeat (2) @(negedge clk_sys);
  endtask
  initial begin
    exp_q.push_back(12'h0ff);
    repeat (16) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (20) @(negedge clk_sys);
    cfg_powerup_teach = 1'h0;
    chk("powerup", 16'(n_done), 16'h1);
    chk("factory", {reserve_level, store_nonvolatile, alignment_mode}, 5'h2);
    teach(12'h0ff, 0);
    @(negedge clk_sys) cmd_mode_toggle = 1'h1;
    @(negedge clk_sys) cmd_mode_toggle = 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("mode", alignment_mode, 1'h1);
    rx_first_level = 8'h80 | 8'($random(seed));
    teach(12'h5ff, 0);
    rx_first_level = 8'h7f;
    teach(12'hd00, 0);
    rx_first_level = 8'hff;
    rx_last_level = 8'h7f;
    teach(12'hd00, 0);
    rx_last_level = 8'h80 | 8'($random(seed));
    beam_blocked = 16'h0008;
    teach(12'hd00, 0);
    blank_areas = 3'h1;
    teach(12'h5ff, 0);
    chk("enable", beam_enable, 16'hffe3);
    blank_areas = 3'h4;
    beam_blocked = 16'h9111;
    teach(12'h5ff, 0);
    chk("four areas", beam_enable, 16'h0444);
    blank_areas = 3'h3;
    teach(12'hd00, 0);
    beam_blocked = 16'h0;
    blank_areas = 3'h0;
    for (int i = 0; i < 2; i++) begin
      npn_config = i[0];
      repeat (8) @(negedge clk_sys);
      for (int j = 0; j < 4; j++) begin
        tms_ctrl_model_inst.pulse((j == 0) ? 10 : (j == 1) ? 20 : (j == 2) ? 80 : 120);
        repeat (20) @(negedge clk_sys);
      end
      teach(12'h5ff, 50);
      teach(12'h5ff, i[0] ? 79 : 21);
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys) reserve_wr = 1'h1;
      reserve_sel = i[2:0];
      @(negedge clk_sys) reserve_wr = 1'h0;
      @(negedge clk_sys);
      chk("reserve", reserve_level, (i < 6) ? i[2:0] : 3'h5);
    end
    @(negedge clk_sys) cfg_nonvolatile_wr = 1'h1;
    cfg_nonvolatile = 1'h0;
    @(negedge clk_sys) cfg_nonvolatile_wr = 1'h0;
    @(negedge clk_sys);
    chk("storage", store_nonvolatile, 1'h0);
    @(negedge clk_sys) cmd_factory_reset = 1'h1;
    @(negedge clk_sys) cmd_factory_reset = 1'h0;
    @(negedge clk_sys);
    chk("defaults", {reserve_level, store_nonvolatile}, 4'h1);
    beam_blocked = 16'($random(seed));
    io_states = 3'($random(seed));
    repeat (3) @(negedge clk_sys);
    chk("total", interrupted_beam_total, 8'($countones(beam_blocked)));
    chk("io", io_view, io_states);
    chk("queue", 16'(exp_q.size()), 16'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
